// >>> ddrcf_ctrl.sv
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module ddrcf_ctrl import ddrcf_pkg::*; #(
	parameter int BURST_BEATS = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic req_valid,
	input wire ddrcf_req_t req,
	output logic req_ready,
	input wire logic wdata_beat,
	input wire logic init_start,
	input wire logic dll_locked,
	output ddrcf_mem_t mem_cmd,
	output logic mem_cke,
	output logic mem_dqs_diff,
	output logic mem_poison
);
	localparam logic [3:0] BEATS = 4'(BURST_BEATS);
	localparam logic [7:0] SETTLE_LAST = 8'(T_DLL_SETTLE_CLK - 1);
	localparam logic [2:0] BURST_LEN = 3'(BURST_CYCLES);
	localparam logic [2:0] AP_LEN = 3'(BURST_CYCLES + AUTO_PRE_CYCLES);

	// Bank index as the memory sees it
	function automatic logic [2:0] bank_of(input logic [2:0] b, input logic octal);
		bank_of = b & {octal, 2'b11};
	endfunction

	// Address hit test, used by the write path only
	function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
		hit = (a == r);
	endfunction

	// ==========================================
	// Register fields
	logic fast_write, startup_sref, octal_bank, poison_inhibit, dqs_diff;
	logic priority_use, power_park, reorder_en, turnaround, init_block;
	logic write_int, read_int, pre_int, swap_same, swap_en;
	logic n_fast_write, n_startup_sref, n_octal_bank, n_poison_inhibit, n_dqs_diff;
	logic n_priority_use, n_power_park, n_reorder_en, n_turnaround, n_init_block;
	logic n_write_int, n_read_int, n_pre_int, n_swap_same, n_swap_en;
	logic dll_lock_s;
	logic wr_en;

	ddrcf_sync u_lock_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(dll_locked),
		.sync_out(dll_lock_s)
	);

	// Software writes land on the access cycle that completes
	always_comb begin
		wr_en = psel && penable && pwrite && pready;
		{n_fast_write, n_startup_sref, n_octal_bank} = {fast_write, startup_sref, octal_bank};
		{n_poison_inhibit, n_dqs_diff, n_priority_use} = {poison_inhibit, dqs_diff, priority_use};
		{n_power_park, n_reorder_en, n_turnaround} = {power_park, reorder_en, turnaround};
		{n_init_block, n_write_int, n_read_int} = {init_block, write_int, read_int};
		{n_pre_int, n_swap_same, n_swap_en} = {pre_int, swap_same, swap_en};
		if (wr_en && hit(paddr, ADDR_STROBE_HI)) begin
			n_fast_write = pwdata[POS_FAST_WRITE];
			n_startup_sref = pwdata[POS_STARTUP_SREF];
			n_octal_bank = pwdata[POS_OCTAL_BANK];
		end
		if (wr_en && hit(paddr, ADDR_STROBE_LO)) begin
			n_poison_inhibit = pwdata[POS_POISON_INHIBIT];
			n_dqs_diff = pwdata[POS_DQS_DIFF];
		end
		if (wr_en && hit(paddr, ADDR_QUEUE_HI)) begin
			n_priority_use = pwdata[POS_PRIORITY_USE];
			n_power_park = pwdata[POS_POWER_PARK];
			n_reorder_en = pwdata[POS_REORDER];
			n_turnaround = pwdata[POS_TURNAROUND];
		end
		if (wr_en && hit(paddr, ADDR_QUEUE_LO)) begin
			n_init_block = pwdata[POS_INIT_BLOCK];
			n_write_int = pwdata[POS_WRITE_INT];
			n_read_int = pwdata[POS_READ_INT];
			n_pre_int = pwdata[POS_PRE_INT];
		end
		if (wr_en && hit(paddr, ADDR_SWAP_HI)) begin
			n_swap_same = pwdata[POS_SWAP_SAME];
			n_swap_en = pwdata[POS_SWAP_EN];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{fast_write, startup_sref, octal_bank} <= {RST_FAST_WRITE, RST_STARTUP_SREF, RST_OCTAL_BANK};
			{poison_inhibit, dqs_diff} <= {RST_POISON_INHIBIT, RST_DQS_DIFF};
			{priority_use, power_park} <= {RST_PRIORITY_USE, RST_POWER_PARK};
			{reorder_en, turnaround} <= {RST_REORDER, RST_TURNAROUND};
			{init_block, write_int, read_int} <= {RST_INIT_BLOCK, RST_WRITE_INT, RST_READ_INT};
			{pre_int, swap_same, swap_en} <= {RST_PRE_INT, RST_SWAP_SAME, RST_SWAP_EN};
		end else begin
			{fast_write, startup_sref, octal_bank} <= {n_fast_write, n_startup_sref, n_octal_bank};
			{poison_inhibit, dqs_diff} <= {n_poison_inhibit, n_dqs_diff};
			{priority_use, power_park} <= {n_priority_use, n_power_park};
			{reorder_en, turnaround} <= {n_reorder_en, n_turnaround};
			{init_block, write_int, read_int} <= {n_init_block, n_write_int, n_read_int};
			{pre_int, swap_same, swap_en} <= {n_pre_int, n_swap_same, n_swap_en};
		end
	end

	// ==========================================
	// APB answer: data prepared in setup, ready in the first access cycle
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr, mapped;

	always_comb begin
		next_prdata = 32'h0000_0000;
		mapped = 1'b1;
		case (paddr)
			ADDR_STROBE_HI: begin
				next_prdata[POS_FAST_WRITE] = fast_write;
				next_prdata[POS_STARTUP_SREF] = startup_sref;
				next_prdata[POS_OCTAL_BANK] = octal_bank;
			end
			ADDR_STROBE_LO: begin
				next_prdata[POS_POISON_INHIBIT] = poison_inhibit;
				next_prdata[POS_DQS_DIFF] = dqs_diff;
				next_prdata[POS_DLL_LOCKED] = dll_lock_s;
			end
			ADDR_QUEUE_HI: begin
				next_prdata[POS_PRIORITY_USE] = priority_use;
				next_prdata[POS_POWER_PARK] = power_park;
				next_prdata[POS_REORDER] = reorder_en;
				next_prdata[POS_TURNAROUND] = turnaround;
			end
			ADDR_QUEUE_LO: begin
				next_prdata[POS_INIT_BLOCK] = init_block;
				next_prdata[POS_WRITE_INT] = write_int;
				next_prdata[POS_READ_INT] = read_int;
				next_prdata[POS_PRE_INT] = pre_int;
			end
			ADDR_SWAP_HI: begin
				next_prdata[POS_SWAP_SAME] = swap_same;
				next_prdata[POS_SWAP_EN] = swap_en;
			end
			ADDR_SWAP_LO: begin
				next_prdata = 32'h0000_0000;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
		if (!(psel && !penable)) begin
			next_prdata = prdata;
		end
		next_pready = psel && !penable;
		next_pslverr = psel && !penable && !mapped;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ==========================================
	// Start-up and park sequencing
	ddrcf_state_t state, next_state;
	logic [7:0] settle_cnt, next_settle_cnt;
	logic run_window, busy;
	ddrcf_cmd_t seq_cmd;
	logic seq_cke;

	always_comb begin
		next_state = state;
		next_settle_cnt = settle_cnt;
		seq_cmd = CMD_NOP;
		seq_cke = mem_cke;
		run_window = 1'b0;
		case (state)
			ST_WAIT: begin
				seq_cke = 1'b0;
				if (init_start) begin
					next_state = startup_sref ? ST_SREF : ST_SETTLE;
					next_settle_cnt = SETTLE_LAST;
				end
			end
			ST_SREF: begin
				seq_cmd = CMD_SELF_REFRESH;
				next_state = ST_SETTLE;
			end
			ST_SETTLE: begin
				seq_cke = !startup_sref;
				run_window = !init_block && !startup_sref;
				next_settle_cnt = settle_cnt - 8'h01;
				if (settle_cnt == 8'h00) begin
					next_state = ST_MODE;
				end
			end
			ST_MODE: begin
				seq_cmd = busy ? CMD_NOP : CMD_MODE_LOAD;
				seq_cke = 1'b1;
				if (!busy) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				seq_cke = 1'b1;
				run_window = !power_park;
				if (power_park && !busy) begin
					next_state = ST_PARK_PRE;
				end
			end
			ST_PARK_PRE: begin
				seq_cmd = CMD_PRE_ALL;
				next_state = ST_PARK;
			end
			ST_PARK: begin
				seq_cke = 1'b0;
				if (!power_park) begin
					next_state = ST_RUN;
				end
			end
			default: begin
				next_state = ST_WAIT;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_WAIT;
			settle_cnt <= 8'h00;
		end else begin
			state <= next_state;
			settle_cnt <= next_settle_cnt;
		end
	end

	// ==========================================
	// Two-slot command queue and issue
	ddrcf_req_t q [2];
	ddrcf_req_t next_q [2];
	ddrcf_req_t cur, next_cur, pick_e;
	logic [1:0] q_valid, next_q_valid, eligible, swapping;
	logic [2:0] burst_cnt, next_burst_cnt, ap_cnt, next_ap_cnt, ap_bank, next_ap_bank;
	logic [1:0] last_cs, next_last_cs;
	logic last_rw, next_last_rw, next_req_ready, sel, any, issue;
	logic [3:0] wcnt, next_wcnt;
	ddrcf_mem_t next_mem_cmd;
	logic next_poison;

	ddrcf_pick u_pick (
		.eligible(eligible),
		.slot0(q[0]),
		.slot1(q[1]),
		.reorder_en(reorder_en),
		.priority_use(priority_use),
		.last_cs(last_cs),
		.sel(sel),
		.any(any)
	);

	// Decide which queued commands may go this cycle
	always_comb begin
		busy = (burst_cnt != 3'h0) || (ap_cnt != 3'h0);
		for (int i = 0; i < 2; i++) begin
			eligible[i] = q_valid[i] && run_window;
			swapping[i] = swap_en && reorder_en && (q[i].prio > cur.prio)
				&& (q[i].port != cur.port || q[i].write != cur.write || swap_same);
			if (burst_cnt != 3'h0) begin
				eligible[i] = eligible[i] && (swapping[i] || (q[i].autopre
					&& q[i].write == cur.write
					&& bank_of(q[i].bank, octal_bank) == bank_of(cur.bank, octal_bank)
					&& (q[i].write ? write_int : read_int)));
			end else if (ap_cnt != 3'h0) begin
				eligible[i] = eligible[i] && pre_int
					&& bank_of(q[i].bank, octal_bank) != ap_bank;
			end
			if (turnaround && last_rw && q[i].cs != last_cs) begin
				eligible[i] = 1'b0;
			end
			if (q[i].write && fast_write && wcnt < BEATS) begin
				eligible[i] = 1'b0;
			end
		end
	end

	// Issue, refill and bookkeeping
	always_comb begin
		next_q = q;
		next_q_valid = q_valid;
		next_cur = cur;
		next_burst_cnt = (burst_cnt != 3'h0) ? burst_cnt - 3'h1 : 3'h0;
		next_ap_cnt = (ap_cnt != 3'h0) ? ap_cnt - 3'h1 : 3'h0;
		next_ap_bank = ap_bank;
		next_last_cs = last_cs;
		next_last_rw = (burst_cnt != 3'h0);
		next_poison = 1'b0;
		issue = any;
		pick_e = q[sel];
		next_mem_cmd = '{cmd: seq_cmd, cs: 2'h0, bank: 3'h0};
		next_wcnt = wcnt;
		if (wdata_beat && wcnt != 4'hf) begin
			next_wcnt = wcnt + 4'h1;
		end
		if (issue) begin
			next_mem_cmd = '{cmd: pick_e.write ? CMD_WRITE : CMD_READ,
				cs: pick_e.cs, bank: bank_of(pick_e.bank, octal_bank)};
			next_poison = pick_e.write && pick_e.uc_err && !poison_inhibit;
			if (burst_cnt != 3'h0 && swapping[sel]) begin
				next_q[sel] = cur;
			end else begin
				next_q_valid[sel] = 1'b0;
			end
			next_cur = pick_e;
			next_burst_cnt = BURST_LEN;
			next_ap_cnt = pick_e.autopre ? AP_LEN : 3'h0;
			next_ap_bank = bank_of(pick_e.bank, octal_bank);
			next_last_cs = pick_e.cs;
			next_last_rw = 1'b1;
			if (pick_e.write && fast_write) begin
				next_wcnt = next_wcnt - BEATS;
			end
		end
		if (!next_q_valid[0] && next_q_valid[1]) begin
			next_q[0] = next_q[1];
			next_q_valid = 2'b01;
		end
		if (req_valid && req_ready) begin
			if (!next_q_valid[0]) begin
				next_q[0] = req;
				next_q_valid[0] = 1'b1;
			end else begin
				next_q[1] = req;
				next_q_valid[1] = 1'b1;
			end
		end
		next_req_ready = !(&next_q_valid);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q[0] <= '0;
			q[1] <= '0;
			q_valid <= 2'b00;
			cur <= '0;
			burst_cnt <= 3'h0;
			ap_cnt <= 3'h0;
			ap_bank <= 3'h0;
			last_cs <= 2'h0;
			last_rw <= 1'b0;
			wcnt <= 4'h0;
			req_ready <= 1'b0;
			mem_cmd <= '{cmd: CMD_NOP, cs: 2'h0, bank: 3'h0};
			mem_cke <= 1'b0;
			mem_dqs_diff <= 1'b0;
			mem_poison <= 1'b0;
		end else begin
			q[0] <= next_q[0];
			q[1] <= next_q[1];
			q_valid <= next_q_valid;
			cur <= next_cur;
			burst_cnt <= next_burst_cnt;
			ap_cnt <= next_ap_cnt;
			ap_bank <= next_ap_bank;
			last_cs <= next_last_cs;
			last_rw <= next_last_rw;
			wcnt <= next_wcnt;
			req_ready <= next_req_ready;
			mem_cmd <= next_mem_cmd;
			mem_cke <= seq_cke;
			mem_dqs_diff <= dqs_diff;
			mem_poison <= next_poison;
		end
	end
endmodule

// >>> ddrcf_ctrl_monitor.sv
`timescale 1ns/1ps
// ==========================================
// Port checker for bus handshake and memory commands
module ddrcf_ctrl_monitor import ddrcf_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic dll_locked,
	input wire ddrcf_mem_t mem_cmd,
	input wire logic mem_cke,
	input wire logic mem_dqs_diff,
	input wire logic mem_poison
);
	logic turn_q;
	logic park_q;
	logic dqs_q;
	logic next_turn_q;
	logic next_park_q;
	logic next_dqs_q;
	logic bus_wr;
	logic rd_lock;
	logic is_rw;
	logic [1:0] cs_now;
	ddrcf_cmd_t cmd_now;

	// Decoded bus accesses and command kind
	assign bus_wr = psel && penable && pready && pwrite;
	assign rd_lock = psel && penable && pready && !pwrite && paddr == ADDR_STROBE_LO;
	assign cmd_now = mem_cmd.cmd;
	assign cs_now = mem_cmd.cs;
	assign is_rw = cmd_now == CMD_READ || cmd_now == CMD_WRITE;

	// Shadow of control bits written over the bus
	always_comb begin
		next_turn_q = turn_q;
		next_park_q = park_q;
		next_dqs_q = dqs_q;
		if (bus_wr && paddr == ADDR_QUEUE_HI) begin
			next_turn_q = pwdata[POS_TURNAROUND];
			next_park_q = pwdata[POS_POWER_PARK];
		end
		if (bus_wr && paddr == ADDR_STROBE_LO) begin
			next_dqs_q = pwdata[POS_DQS_DIFF];
		end
	end

	// Shadow registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			turn_q <= RST_TURNAROUND;
			park_q <= RST_POWER_PARK;
			dqs_q <= RST_DQS_DIFF;
		end else begin
			turn_q <= next_turn_q;
			park_q <= next_park_q;
			dqs_q <= next_dqs_q;
		end
	end

	// ==========================================
	// Properties
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup; psel && !penable; endsequence
	sequence s_park_entry; park_q && $fell(mem_cke); endsequence
	property p_apb_ready; s_setup |=> pready; endproperty
	property p_ready_pulse; pready |=> !pready; endproperty
	property p_slverr; pslverr |-> pready; endproperty
	property p_poison; mem_poison |-> cmd_now == CMD_WRITE; endproperty
	property p_cmd_single; is_rw |=> cmd_now == CMD_NOP; endproperty
	property p_turn; turn_q && is_rw |=> ##1 !(is_rw && cs_now != $past(cs_now, 2)); endproperty
	property p_park_hold; park_q && !mem_cke |-> cmd_now == CMD_NOP; endproperty
	property p_park_pre;
		s_park_entry |-> $past(cmd_now, 1) == CMD_PRE_ALL || $past(cmd_now, 2) == CMD_PRE_ALL;
	endproperty
	property p_dqs; $changed(dqs_q) |-> ##[1:3] mem_dqs_diff == dqs_q; endproperty
	property p_dll; rd_lock |-> prdata[0] == $past(dll_locked, 3); endproperty

	a_apb_ready: assert property (p_apb_ready) else $error("no ready after setup");
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
	a_slverr: assert property (p_slverr) else $error("error without ready");
	a_poison: assert property (p_poison) else $error("poison without write");
	a_cmd_single: assert property (p_cmd_single) else $error("command not single");
	a_turn: assert property (p_turn) else $error("no turnaround cycle");
	a_park_hold: assert property (p_park_hold) else $error("command while parked");
	a_park_pre: assert property (p_park_pre) else $error("park without precharge");
	a_dqs: assert property (p_dqs) else $error("strobe style not applied");
	a_dll: assert property (p_dll) else $error("lock flag not synchronised");
endmodule

// >>> ddrcf_mem_model.sv
`timescale 1ns/1ps
// ==========================================
// Memory side: DLL lock source and command log
module ddrcf_mem_model import ddrcf_pkg::*; #(
	parameter int LOCK_DELAY = 60
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire ddrcf_mem_t mem_cmd,
	output logic dll_locked
);
	ddrcf_cmd_t cmds[$];
	int stamps[$];
	int cyc;

	// Lock comes a fixed time after reset; each command is logged with its cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyc <= 0;
			dll_locked <= 1'b0;
		end else begin
			cyc <= cyc + 1;
			if (cyc == LOCK_DELAY) begin
				dll_locked <= 1'b1;
			end
			if (mem_cmd.cmd != CMD_NOP) begin
				cmds.push_back(mem_cmd.cmd);
				stamps.push_back(cyc);
			end
		end
	end
endmodule

// >>> ddrcf_pick.sv
`timescale 1ns/1ps
module ddrcf_pick import ddrcf_pkg::*; (
	input wire logic [1:0] eligible,
	input wire ddrcf_req_t slot0,
	input wire ddrcf_req_t slot1,
	input wire logic reorder_en,
	input wire logic priority_use,
	input wire logic [1:0] last_cs,
	output logic sel,
	output logic any
);
	// Chooses the slot to issue; in order unless reordering is on
	always_comb begin
		sel = 1'b0;
		any = eligible[0];
		if (reorder_en) begin
			any = |eligible;
			if (!eligible[0]) begin
				sel = 1'b1;
			end else if (eligible[1]) begin
				if (priority_use && slot1.prio != slot0.prio) begin
					sel = slot1.prio > slot0.prio;
				end else begin
					sel = (slot1.cs == last_cs) && (slot0.cs != last_cs);
				end
			end
		end
	end
endmodule

// >>> ddrcf_pkg.sv
package ddrcf_pkg;

	// ==========================================
	// Register map (64-bit registers as two words)
	localparam logic [11:0] ADDR_STROBE_LO = 12'h010;
	localparam logic [11:0] ADDR_STROBE_HI = 12'h014;
	localparam logic [11:0] ADDR_QUEUE_LO = 12'h020;
	localparam logic [11:0] ADDR_QUEUE_HI = 12'h024;
	localparam logic [11:0] ADDR_SWAP_LO = 12'h030;
	localparam logic [11:0] ADDR_SWAP_HI = 12'h034;

	// ==========================================
	// Field positions inside each 32-bit word
	localparam int POS_FAST_WRITE = 16;
	localparam int POS_STARTUP_SREF = 8;
	localparam int POS_OCTAL_BANK = 0;
	localparam int POS_POISON_INHIBIT = 24;
	localparam int POS_DQS_DIFF = 16;
	localparam int POS_DLL_LOCKED = 0;
	localparam int POS_PRIORITY_USE = 24;
	localparam int POS_POWER_PARK = 16;
	localparam int POS_REORDER = 8;
	localparam int POS_TURNAROUND = 0;
	localparam int POS_INIT_BLOCK = 24;
	localparam int POS_WRITE_INT = 16;
	localparam int POS_READ_INT = 8;
	localparam int POS_PRE_INT = 0;
	localparam int POS_SWAP_SAME = 24;
	localparam int POS_SWAP_EN = 16;

	// ==========================================
	// Reset values of the fields
	localparam logic RST_FAST_WRITE = 1'b0;
	localparam logic RST_STARTUP_SREF = 1'b0;
	localparam logic RST_OCTAL_BANK = 1'b0;
	localparam logic RST_POISON_INHIBIT = 1'b0;
	localparam logic RST_DQS_DIFF = 1'b0;
	localparam logic RST_PRIORITY_USE = 1'b1;
	localparam logic RST_POWER_PARK = 1'b0;
	localparam logic RST_REORDER = 1'b1;
	localparam logic RST_TURNAROUND = 1'b1;
	localparam logic RST_INIT_BLOCK = 1'b0;
	localparam logic RST_WRITE_INT = 1'b0;
	localparam logic RST_READ_INT = 1'b0;
	localparam logic RST_PRE_INT = 1'b0;
	localparam logic RST_SWAP_SAME = 1'b1;
	localparam logic RST_SWAP_EN = 1'b1;

	// ==========================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_DLL_SETTLE_CLK = 200;
	localparam int T_AUTO_PRE_NS = 15;
	localparam int AUTO_PRE_CYCLES = (T_AUTO_PRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BURST_CYCLES = 2;

	// ==========================================
	// Types
	typedef enum logic [2:0] {
		CMD_NOP = 3'h0,
		CMD_READ = 3'h1,
		CMD_WRITE = 3'h2,
		CMD_PRE_ALL = 3'h3,
		CMD_SELF_REFRESH = 3'h4,
		CMD_MODE_LOAD = 3'h5
	} ddrcf_cmd_t;

	typedef enum logic [6:0] {
		ST_WAIT = 7'h01,
		ST_SREF = 7'h02,
		ST_SETTLE = 7'h04,
		ST_MODE = 7'h08,
		ST_RUN = 7'h10,
		ST_PARK_PRE = 7'h20,
		ST_PARK = 7'h40
	} ddrcf_state_t;

	typedef struct packed {
		logic write;
		logic autopre;
		logic port;
		logic [1:0] prio;
		logic [1:0] cs;
		logic [2:0] bank;
		logic uc_err;
	} ddrcf_req_t;

	typedef struct packed {
		ddrcf_cmd_t cmd;
		logic [1:0] cs;
		logic [2:0] bank;
	} ddrcf_mem_t;

endpackage

// >>> ddrcf_sync.sv
`timescale 1ns/1ps
module ddrcf_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic async_in,
	output logic sync_out
);
	logic stage1;
	logic next_stage1;
	logic next_sync_out;

	// Two-flop crossing; first stage feeds only the second
	always_comb begin
		next_stage1 = async_in;
		next_sync_out = stage1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1 <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			stage1 <= next_stage1;
			sync_out <= next_sync_out;
		end
	end
endmodule

// >>> test_ddr2_ctrl_config_fields.sv
`timescale 1ns/1ps
// ==========================================
// Register bus and command port sequences
module test_ddr2_ctrl_config_fields import ddrcf_pkg::*; ;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic req_valid;
	ddrcf_req_t req;
	logic req_ready;
	logic wdata_beat;
	logic init_start;
	logic dll_locked;
	ddrcf_mem_t mem_cmd;
	logic mem_cke;
	logic mem_dqs_diff;
	logic mem_poison;
	int n_errors;
	int check_count;
	int waited;
	int base;
	logic [31:0] rd;
	logic err;
	logic [11:0] addrs[6] = '{ADDR_STROBE_LO, ADDR_STROBE_HI, ADDR_QUEUE_LO, ADDR_QUEUE_HI,
		ADDR_SWAP_LO, ADDR_SWAP_HI};
	logic [31:0] rstv[6] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0100_0101,
		32'h0000_0000, 32'h0101_0000};

	ddrcf_ctrl u_ddrcf_ctrl (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.req_valid(req_valid), .req(req), .req_ready(req_ready), .wdata_beat(wdata_beat),
		.init_start(init_start), .dll_locked(dll_locked), .mem_cmd(mem_cmd),
		.mem_cke(mem_cke), .mem_dqs_diff(mem_dqs_diff), .mem_poison(mem_poison)
	);
	ddrcf_mem_model u_ddrcf_mem_model (
		.pclk(pclk), .presetn(presetn), .mem_cmd(mem_cmd), .dll_locked(dll_locked)
	);

	// Clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Verdict and end of run
	task automatic final_report();
		if (n_errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Comparisons
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chkb(input string nm, input logic e, input logic g);
		chk(nm, {31'h0000_0000, e}, {31'h0000_0000, g});
	endtask
	task automatic hang(input string nm);
		n_errors++;
		$display("Error %s expected response seen none", nm);
		final_report();
	endtask

	// One bus transfer, held until ready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) hang("bus ready");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, e, rd);
	endtask

	// Command offer, held until taken; priority follows chip select
	task automatic send(input logic w, input logic [1:0] cs, input logic uc);
		@(posedge pclk);
		req_valid <= 1'b1;
		req <= '{w, 1'b0, 1'b0, cs, cs, {cs[1], 2'b01}, uc};
		waited = 0;
		do begin
			@(posedge pclk);
			waited++;
		end while (req_ready !== 1'b1 && waited < 50);
		if (req_ready !== 1'b1) hang("request taken");
		req_valid <= 1'b0;
	endtask
	task automatic wait_cmd(input ddrcf_cmd_t c, input int lim);
		waited = 0;
		while (mem_cmd.cmd !== c && waited < lim) begin
			@(posedge pclk);
			waited++;
		end
		if (mem_cmd.cmd !== c) hang("memory command");
	endtask
	task automatic start_init();
		@(posedge pclk);
		init_start <= 1'b1;
		@(posedge pclk);
		init_start <= 1'b0;
	endtask
	task automatic beats();
		wdata_beat <= 1'b1;
		repeat (4) @(posedge pclk);
		wdata_beat <= 1'b0;
	endtask

	// Main sequence
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		req_valid = 1'b0;
		req = '0;
		wdata_beat = 1'b0;
		init_start = 1'b0;
		n_errors = 0;
		check_count = 0;
		presetn = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		foreach (addrs[i]) rchk(addrs[i], rstv[i], "reset value");
		apb(1'b0, 12'h040, 32'h0000_0000);
		chkb("unmapped error", 1'b1, err);
		apb(1'b1, ADDR_STROBE_LO, 32'h0101_0001);
		rchk(ADDR_STROBE_LO, 32'h0101_0000, "strobe word");
		chkb("strobe style", 1'b1, mem_dqs_diff);
		apb(1'b1, ADDR_STROBE_LO, 32'h0000_0000);
		waited = 0;
		do begin
			apb(1'b0, ADDR_STROBE_LO, 32'h0000_0000);
			waited++;
		end while (rd[0] !== 1'b1 && waited < 100);
		chkb("lock flag", 1'b1, rd[0]);
		apb(1'b1, ADDR_STROBE_HI, 32'h0001_0000);
		apb(1'b1, ADDR_QUEUE_LO, 32'h0100_0000);
		send(1'b0, 2'd0, 1'b0);
		start_init();
		wait_cmd(CMD_READ, 400);
		chkb("settle blocked", 1'b1, waited >= T_DLL_SETTLE_CLK);
		send(1'b1, 2'd0, 1'b1);
		repeat (8) @(posedge pclk);
		chk("write held", 32'h0000_0002, u_ddrcf_mem_model.cmds.size());
		beats();
		wait_cmd(CMD_WRITE, 20);
		chkb("poison", 1'b1, mem_poison);
		apb(1'b1, ADDR_STROBE_LO, 32'h0100_0000);
		send(1'b1, 2'd0, 1'b1);
		beats();
		wait_cmd(CMD_WRITE, 20);
		chkb("poison inhibited", 1'b0, mem_poison);
		@(posedge pclk);
		base = u_ddrcf_mem_model.cmds.size();
		send(1'b0, 2'd0, 1'b0);
		send(1'b0, 2'd1, 1'b0);
		repeat (12) @(posedge pclk);
		chk("reads issued", base + 2, u_ddrcf_mem_model.cmds.size());
		waited = u_ddrcf_mem_model.stamps[base + 1] - u_ddrcf_mem_model.stamps[base];
		chk("turnaround gap", 32'h0000_0004, waited);
		apb(1'b1, ADDR_QUEUE_HI, 32'h0101_0101);
		waited = 0;
		while (mem_cke !== 1'b0 && waited < 20) begin
			@(posedge pclk);
			waited++;
		end
		base = u_ddrcf_mem_model.cmds.size();
		chk("precharge all", CMD_PRE_ALL, u_ddrcf_mem_model.cmds[base - 1]);
		chkb("clock enable low", 1'b0, mem_cke);
		send(1'b0, 2'd0, 1'b0);
		send(1'b0, 2'd2, 1'b0);
		repeat (20) @(posedge pclk);
		chk("commands withheld", base, u_ddrcf_mem_model.cmds.size());
		apb(1'b1, ADDR_QUEUE_HI, 32'h0100_0101);
		wait_cmd(CMD_READ, 40);
		chk("priority pick", 32'h0000_0002, mem_cmd.cs);
		chk("bank masked", 32'h0000_0001, mem_cmd.bank);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		base = u_ddrcf_mem_model.cmds.size();
		apb(1'b1, ADDR_STROBE_HI, 32'h0000_0101);
		start_init();
		wait_cmd(CMD_MODE_LOAD, 400);
		repeat (2) @(posedge pclk);
		chk("startup refresh", CMD_SELF_REFRESH, u_ddrcf_mem_model.cmds[base]);
		send(1'b0, 2'd2, 1'b0);
		wait_cmd(CMD_READ, 20);
		chk("bank full", 32'h0000_0005, mem_cmd.bank);
		final_report();
	end
endmodule

bind ddrcf_ctrl ddrcf_ctrl_monitor u_ddrcf_ctrl_monitor (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.dll_locked(dll_locked), .mem_cmd(mem_cmd), .mem_cke(mem_cke),
	.mem_dqs_diff(mem_dqs_diff), .mem_poison(mem_poison)
);
